// File: mxu_message_exchange_unit.sv
// message exchange unit: doorbells, message registers, four queues
// assumes host and core request ports are synchronous to core_clk
// the host line is open drain: it drives low only, enabled when pending
`timescale 1ns/1ps
`include "mxu_map.svh"

module mxu_message_exchange_unit import mxu_pkg::*; #(
	parameter int DEPTH = `MXU_Q_DEPTH
) (
	input wire logic core_clk, // unit clock, 100 MHz
	input wire logic nrst, // async reset, active low
	input wire mxu_req_t host_req, // access from the remote host side
	output logic host_ready, // host request can be taken
	output mxu_rsp_t host_rsp, // host read answer
	input wire mxu_req_t core_req, // access from the local core side
	output logic core_ready, // core request can be taken
	output mxu_rsp_t core_rsp, // core read answer
	output logic core_irq, // interrupt request to local core
	output logic inta_lvl, // host line level when driven
	output logic inta_oe_n // host line enable, low while driving
);

	// --------------------------------------------------------------
	// decode helpers
	// --------------------------------------------------------------
	function automatic logic is_tgt(input mxu_req_t r, input mxu_tgt_t t);
		is_tgt = r.valid && (r.target == t);
	endfunction : is_tgt

	function automatic logic is_wr(input mxu_req_t r, input mxu_tgt_t t);
		is_wr = is_tgt(r, t) && r.write;
	endfunction : is_wr

	function automatic logic is_rd(input mxu_req_t r, input mxu_tgt_t t);
		is_rd = is_tgt(r, t) && !r.write;
	endfunction : is_rd

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [`MXU_DATA_W-1:0] in_db_reg;
	logic [`MXU_DATA_W-1:0] out_db_reg;
	logic [`MXU_DATA_W-1:0] in_msg_reg [`MXU_NUM_MSG];
	logic [`MXU_DATA_W-1:0] out_msg_reg [`MXU_NUM_MSG];
	logic [`MXU_NUM_MSG-1:0] in_msg_pend_reg;
	logic [`MXU_NUM_MSG-1:0] out_msg_pend_reg;

	logic host_take;
	logic core_take;
	logic [`MXU_NUM_Q-1:0] q_push;
	logic [`MXU_NUM_Q-1:0] q_pop;
	logic [`MXU_NUM_Q-1:0] q_ready;
	logic [`MXU_NUM_Q-1:0] q_avail;
	logic [`MXU_DATA_W-1:0] q_wdata [`MXU_NUM_Q];
	logic [`MXU_DATA_W-1:0] q_rdata [`MXU_NUM_Q];
	logic host_rd_q_reg;
	logic core_rd_q_reg;
	logic [0:0] host_rd_qi_reg;
	logic [0:0] core_rd_qi_reg;
	logic [`MXU_DATA_W-1:0] host_rd_word_reg;
	logic [`MXU_DATA_W-1:0] core_rd_word_reg;
	logic host_rvalid_reg;
	logic core_rvalid_reg;

	// --------------------------------------------------------------
	// flow control: only a push into a full queue is held off
	// --------------------------------------------------------------
	assign host_ready = !(host_req.valid && host_req.write &&
		((host_req.target == `MXU_TGT_IN_Q0 && !q_ready[0]) ||
		(host_req.target == `MXU_TGT_IN_Q1 && !q_ready[1])));
	assign core_ready = !(core_req.valid && core_req.write &&
		((core_req.target == `MXU_TGT_OUT_Q0 && !q_ready[2]) ||
		(core_req.target == `MXU_TGT_OUT_Q1 && !q_ready[3])));
	assign host_take = host_req.valid && host_ready;
	assign core_take = core_req.valid && core_ready;

	// --------------------------------------------------------------
	// doorbells; set wins over a clear in the same cycle
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			in_db_reg <= `MXU_RST_WORD;
		end else begin
			in_db_reg <= (in_db_reg & ~(is_wr(core_req, `MXU_TGT_IN_DB) ?
				core_req.wdata : '0)) |
				(is_wr(host_req, `MXU_TGT_IN_DB) ? host_req.wdata : '0);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			out_db_reg <= `MXU_RST_WORD;
		end else begin
			out_db_reg <= (out_db_reg & ~(is_wr(host_req, `MXU_TGT_OUT_DB) ?
				host_req.wdata : '0)) |
				(is_wr(core_req, `MXU_TGT_OUT_DB) ? core_req.wdata : '0);
		end
	end

	// --------------------------------------------------------------
	// message registers; a read by the receiver retires its pending bit
	// --------------------------------------------------------------
	genvar m;
	generate
		for (m = 0; m < `MXU_NUM_MSG; m++) begin : g_msg
			localparam mxu_tgt_t IN_T = `MXU_TGT_IN_MSG0 + mxu_tgt_t'(m);
			localparam mxu_tgt_t OUT_T = `MXU_TGT_OUT_MSG0 + mxu_tgt_t'(m);

			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					in_msg_reg[m] <= `MXU_RST_WORD;
					in_msg_pend_reg[m] <= 1'b0;
				end else begin
					if (is_wr(host_req, IN_T)) begin
						in_msg_reg[m] <= host_req.wdata;
					end
					in_msg_pend_reg[m] <= is_wr(host_req, IN_T) ||
						(in_msg_pend_reg[m] && !is_rd(core_req, IN_T));
				end
			end

			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					out_msg_reg[m] <= `MXU_RST_WORD;
					out_msg_pend_reg[m] <= 1'b0;
				end else begin
					if (is_wr(core_req, OUT_T)) begin
						out_msg_reg[m] <= core_req.wdata;
					end
					out_msg_pend_reg[m] <= is_wr(core_req, OUT_T) ||
						(out_msg_pend_reg[m] && !is_rd(host_req, OUT_T));
				end
			end
		end
	endgenerate

	// --------------------------------------------------------------
	// queues: 0,1 inbound (host pushes, core pops), 2,3 outbound
	// --------------------------------------------------------------
	genvar q;
	generate
		for (q = 0; q < `MXU_NUM_Q; q++) begin : g_q
			localparam bit INB = (q < 2);
			localparam mxu_tgt_t T = INB ? `MXU_TGT_IN_Q0 + mxu_tgt_t'(q) :
				`MXU_TGT_OUT_Q0 + mxu_tgt_t'(q - 2);
			mxu_req_t src;
			mxu_req_t dst;

			assign src = INB ? host_req : core_req;
			assign dst = INB ? core_req : host_req;
			assign q_push[q] = is_wr(src, T);
			assign q_pop[q] = is_rd(dst, T);
			assign q_wdata[q] = src.wdata;

			mxu_msg_queue #(
				.DW(`MXU_DATA_W),
				.DEPTH(DEPTH)
			) u_queue (
				.core_clk(core_clk),
				.nrst(nrst),
				.push_valid(q_push[q]),
				.push_data(q_wdata[q]),
				.push_ready(q_ready[q]),
				.pop_valid(q_pop[q]),
				.pop_data(q_rdata[q]),
				.not_empty(q_avail[q])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// read answers, one cycle after the request
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			host_rvalid_reg <= 1'b0;
			host_rd_q_reg <= 1'b0;
			host_rd_qi_reg <= '0;
			host_rd_word_reg <= `MXU_RST_WORD;
		end else begin
			host_rvalid_reg <= host_take && !host_req.write;
			host_rd_q_reg <= is_rd(host_req, `MXU_TGT_OUT_Q0) ||
				is_rd(host_req, `MXU_TGT_OUT_Q1);
			host_rd_qi_reg <= host_req.target == `MXU_TGT_OUT_Q1;
			case (host_req.target)
				`MXU_TGT_IN_DB: host_rd_word_reg <= in_db_reg;
				`MXU_TGT_OUT_DB: host_rd_word_reg <= out_db_reg;
				`MXU_TGT_IN_MSG0: host_rd_word_reg <= in_msg_reg[0];
				`MXU_TGT_IN_MSG1: host_rd_word_reg <= in_msg_reg[1];
				`MXU_TGT_OUT_MSG0: host_rd_word_reg <= out_msg_reg[0];
				`MXU_TGT_OUT_MSG1: host_rd_word_reg <= out_msg_reg[1];
				default: host_rd_word_reg <= `MXU_UNMAPPED_WORD;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			core_rvalid_reg <= 1'b0;
			core_rd_q_reg <= 1'b0;
			core_rd_qi_reg <= '0;
			core_rd_word_reg <= `MXU_RST_WORD;
		end else begin
			core_rvalid_reg <= core_take && !core_req.write;
			core_rd_q_reg <= is_rd(core_req, `MXU_TGT_IN_Q0) ||
				is_rd(core_req, `MXU_TGT_IN_Q1);
			core_rd_qi_reg <= core_req.target == `MXU_TGT_IN_Q1;
			case (core_req.target)
				`MXU_TGT_IN_DB: core_rd_word_reg <= in_db_reg;
				`MXU_TGT_OUT_DB: core_rd_word_reg <= out_db_reg;
				`MXU_TGT_IN_MSG0: core_rd_word_reg <= in_msg_reg[0];
				`MXU_TGT_IN_MSG1: core_rd_word_reg <= in_msg_reg[1];
				`MXU_TGT_OUT_MSG0: core_rd_word_reg <= out_msg_reg[0];
				`MXU_TGT_OUT_MSG1: core_rd_word_reg <= out_msg_reg[1];
				default: core_rd_word_reg <= `MXU_UNMAPPED_WORD;
			endcase
		end
	end

	// queue words come registered from the queue itself, so only a mux here
	assign host_rsp.valid = host_rvalid_reg;
	assign host_rsp.data = host_rd_q_reg ? q_rdata[2 + int'(host_rd_qi_reg)] :
		host_rd_word_reg;
	assign core_rsp.valid = core_rvalid_reg;
	assign core_rsp.data = core_rd_q_reg ? q_rdata[int'(core_rd_qi_reg)] :
		core_rd_word_reg;

	// --------------------------------------------------------------
	// interrupt outputs, registered so they never glitch
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			core_irq <= 1'b0;
		end else begin
			core_irq <= (|in_db_reg) || (|in_msg_pend_reg) || (|q_avail[1:0]);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			inta_oe_n <= 1'b1;
		end else begin
			inta_oe_n <= !((|out_db_reg) || (|out_msg_pend_reg) || (|q_avail[3:2]));
		end
	end

	assign inta_lvl = 1'b0;

endmodule : mxu_message_exchange_unit

// File: mxu_map.svh
// constants of the message exchange unit: codes, reset values, queue sizes
// assumes inclusion by the package and by every design file that decodes requests
`ifndef MXU_MAP_SVH
`define MXU_MAP_SVH

`define MXU_DATA_W 32
`define MXU_TGT_W 4
`define MXU_NUM_MSG 2
`define MXU_NUM_Q 4
`define MXU_Q_DEPTH 16

// request target codes
`define MXU_TGT_IN_DB 4'h0
`define MXU_TGT_OUT_DB 4'h1
`define MXU_TGT_IN_MSG0 4'h2
`define MXU_TGT_IN_MSG1 4'h3
`define MXU_TGT_OUT_MSG0 4'h4
`define MXU_TGT_OUT_MSG1 4'h5
`define MXU_TGT_IN_Q0 4'h6
`define MXU_TGT_IN_Q1 4'h7
`define MXU_TGT_OUT_Q0 4'h8
`define MXU_TGT_OUT_Q1 4'h9

`define MXU_RST_WORD 32'h0000_0000
`define MXU_EMPTY_WORD 32'hffff_ffff
`define MXU_UNMAPPED_WORD 32'h0000_0000

`endif

// File: mxu_pkg.sv
// types shared by the message exchange unit and its queues
// assumes mxu_map.svh sits in the include path
`include "mxu_map.svh"

package mxu_pkg;

	typedef logic [`MXU_TGT_W-1:0] mxu_tgt_t;

	// one access from either side: write carries wdata, read answers next cycle
	typedef struct packed {
		logic valid;
		logic write;
		mxu_tgt_t target;
		logic [`MXU_DATA_W-1:0] wdata;
	} mxu_req_t;

	typedef struct packed {
		logic valid;
		logic [`MXU_DATA_W-1:0] data;
	} mxu_rsp_t;

endpackage : mxu_pkg

// File: mxu_msg_queue.sv
// one message queue: word array with push and pop sides
// assumes a single clock; a pop while empty leaves the pointers and count alone
`timescale 1ns/1ps
`include "mxu_map.svh"

module mxu_msg_queue import mxu_pkg::*; #(
	parameter int DW = `MXU_DATA_W,
	parameter int DEPTH = `MXU_Q_DEPTH
) (
	input wire logic core_clk, // unit clock
	input wire logic nrst, // async reset, active low
	input wire logic push_valid, // push a word this cycle
	input wire logic [DW-1:0] push_data, // word to push
	output logic push_ready, // room for one more word
	input wire logic pop_valid, // take the oldest word
	output logic [DW-1:0] pop_data, // registered word taken
	output logic not_empty // holds at least one word
);

	localparam int AW = $clog2(DEPTH);

	logic [DW-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic do_push;
	logic do_pop;

	assign push_ready = (count_reg != (AW+1)'(DEPTH));
	assign not_empty = (count_reg != '0);
	assign do_push = push_valid && push_ready;
	assign do_pop = pop_valid && not_empty;

	// storage has no reset, pointers, count and pop_data do
	always_ff @(posedge core_clk) begin
		if (do_push) begin
			mem[wr_ptr_reg] <= push_data;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else if (do_push && !do_pop) begin
			count_reg <= count_reg + 1'b1;
		end else if (do_pop && !do_push) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	// an empty pop answers with the empty marker word
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pop_data <= `MXU_RST_WORD;
		end else if (pop_valid) begin
			pop_data <= not_empty ? mem[rd_ptr_reg] : `MXU_EMPTY_WORD;
		end
	end

endmodule : mxu_msg_queue

// File: mxu_message_exchange_unit_chk.sv
// checker for the message exchange unit, bound to its top module
// assumes one clock domain and the target codes of mxu_map.svh
`timescale 1ns/1ps
`include "mxu_map.svh"

module mxu_message_exchange_unit_chk import mxu_pkg::*; #(
	parameter int DEPTH = `MXU_Q_DEPTH
) (
	input wire logic core_clk, // unit clock
	input wire logic nrst, // async reset
	input wire mxu_req_t host_req, // host access
	input wire logic host_ready, // host ready
	input wire mxu_rsp_t host_rsp, // host answer
	input wire mxu_req_t core_req, // core access
	input wire logic core_ready, // core ready
	input wire mxu_rsp_t core_rsp, // core answer
	input wire logic core_irq, // core interrupt
	input wire logic inta_lvl, // host line level
	input wire logic inta_oe_n // host line enable
);
	// ---
	// properties
	// ---
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic h_wr = host_req.valid && host_ready && host_req.write;
	wire logic c_wr = core_req.valid && core_ready && core_req.write;
	wire logic c_acc = core_req.valid && core_ready;

	db_irq_a: assert property (h_wr && host_req.target == `MXU_TGT_IN_DB
		&& host_req.wdata != 0 |-> ##2 core_irq) else $error("doorbell missed core irq");
	out_db_a: assert property (c_wr && core_req.target == `MXU_TGT_OUT_DB
		&& core_req.wdata != 0 |-> ##2 !inta_oe_n) else $error("doorbell missed host line");
	in_msg_a: assert property (h_wr && host_req.target inside {`MXU_TGT_IN_MSG0,
		`MXU_TGT_IN_MSG1} |-> ##2 core_irq) else $error("message missed core irq");
	out_msg_a: assert property (c_wr && core_req.target inside {`MXU_TGT_OUT_MSG0,
		`MXU_TGT_OUT_MSG1} |-> ##2 !inta_oe_n) else $error("message missed host line");
	in_q_a: assert property (h_wr && host_req.target inside {`MXU_TGT_IN_Q0,
		`MXU_TGT_IN_Q1} |-> ##2 core_irq) else $error("queue missed core irq");
	out_q_a: assert property (c_wr && core_req.target inside {`MXU_TGT_OUT_Q0,
		`MXU_TGT_OUT_Q1} |-> ##2 !inta_oe_n) else $error("queue missed host line");
	line_low_a: assert property (inta_lvl == 1'b0) else $error("host line level not low");
	line_hold_a: assert property ($rose(inta_oe_n) |->
		$past(host_req.valid && host_ready, 2)) else $error("host line dropped unasked");
	irq_hold_a: assert property ($fell(core_irq) |-> $past(c_acc, 2))
		else $error("core irq dropped unasked");
	host_rsp_a: assert property (host_req.valid && host_ready && !host_req.write
		|=> host_rsp.valid) else $error("host read unanswered");
	core_rsp_a: assert property (core_rsp.valid |->
		$past(c_acc && !core_req.write)) else $error("core answer without read");
endmodule : mxu_message_exchange_unit_chk

bind mxu_message_exchange_unit mxu_message_exchange_unit_chk #(.DEPTH(DEPTH)) chk_u (
	.core_clk(core_clk), .nrst(nrst), .host_req(host_req), .host_ready(host_ready),
	.host_rsp(host_rsp), .core_req(core_req), .core_ready(core_ready), .core_rsp(core_rsp),
	.core_irq(core_irq), .inta_lvl(inta_lvl), .inta_oe_n(inta_oe_n));

// File: mxu_host_model.sv
// remote host model: issues word accesses on the host request port
// assumes requests change just after a rising edge, held until taken
`timescale 1ns/1ps

module mxu_host_model import mxu_pkg::*; (
	input wire logic core_clk, // unit clock
	output mxu_req_t host_req, // access to the unit
	input wire logic host_ready, // unit takes it
	input wire mxu_rsp_t host_rsp // read answer
);
	initial host_req = '0;

	// released data is inverted so a stale word never looks valid
	task automatic acc(input logic w, input mxu_tgt_t t, input logic [31:0] d);
		@(posedge core_clk);
		host_req <= '{1'b1, w, t, d};
		@(negedge core_clk);
		while (!host_ready) @(negedge core_clk);
		@(posedge core_clk);
		host_req.valid <= 1'b0;
		host_req.wdata <= ~d;
	endtask : acc

	// clears on the outbound doorbell are written as ones here
	task automatic wr(input mxu_tgt_t t, input logic [31:0] d);
		acc(1'b1, t, d);
	endtask : wr

	task automatic rd(input mxu_tgt_t t, output logic v, output logic [31:0] d);
		acc(1'b0, t, 32'h0000_0000);
		@(negedge core_clk);
		v = host_rsp.valid;
		d = host_rsp.data;
	endtask : rd
endmodule : mxu_host_model

// File: testbench.sv
// self-checking bench for the message exchange unit with a host model
// assumes queue depth 2 so that full queues are reached quickly
`timescale 1ns/1ps
`include "mxu_map.svh"

module testbench import mxu_pkg::*; ;
	logic core_clk, nrst, host_ready, core_ready, core_irq, inta_lvl, inta_oe_n;
	mxu_req_t host_req, core_req;
	mxu_rsp_t host_rsp, core_rsp;
	int error_cnt = 0, tests_run = 0, seed = 21;
	logic [31:0] mq[$];
	logic [31:0] d;

	mxu_message_exchange_unit #(.DEPTH(2)) dut_u (.core_clk(core_clk), .nrst(nrst),
		.host_req(host_req), .host_ready(host_ready), .host_rsp(host_rsp),
		.core_req(core_req), .core_ready(core_ready), .core_rsp(core_rsp),
		.core_irq(core_irq), .inta_lvl(inta_lvl), .inta_oe_n(inta_oe_n));
	mxu_host_model host_u (.core_clk(core_clk), .host_req(host_req),
		.host_ready(host_ready), .host_rsp(host_rsp));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask : chk

	task automatic end_of_test();
		$display("errors %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test

	task automatic core_acc(input logic w, input mxu_tgt_t t, input logic [31:0] x);
		@(posedge core_clk);
		core_req <= '{1'b1, w, t, x};
		@(negedge core_clk);
		while (!core_ready) @(negedge core_clk);
		@(posedge core_clk);
		core_req.valid <= 1'b0;
		core_req.wdata <= ~x;
	endtask : core_acc

	// one side's write, the other side's read: h=1 is the host
	task automatic put(input logic h, input mxu_tgt_t t, input logic [31:0] x);
		if (h) host_u.wr(t, x);
		else core_acc(1'b1, t, x);
	endtask : put

	task automatic get(input logic h, input mxu_tgt_t t, input logic [31:0] e);
		logic ok;
		logic [31:0] s;
		if (h) host_u.rd(t, ok, s);
		else begin
			core_acc(1'b0, t, 32'h0000_0000);
			@(negedge core_clk);
			ok = core_rsp.valid;
			s = core_rsp.data;
		end
		chk("rsp valid", 32'h1, {31'h0, ok});
		chk("rsp data", e, s);
	endtask : get

	// interrupts are registered one edge behind the state
	task automatic settle(input logic irq, input logic oe_n);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("core_irq", {31'h0, irq}, {31'h0, core_irq});
		chk("inta_oe_n", {31'h0, oe_n}, {31'h0, inta_oe_n});
		chk("inta_lvl", 32'h0, {31'h0, inta_lvl});
	endtask : settle

	task automatic q_test(input logic inb, input mxu_tgt_t t);
		repeat (2) begin
			d = $random(seed);
			mq.push_back(d);
			put(inb, t, d);
			settle(inb, inb);
		end
		d = $random(seed);
		mq.push_back(d);
		fork
			put(inb, t, d);
			begin
				@(posedge core_clk);
				@(negedge core_clk);
				chk("ready", 32'h0, {31'h0, inb ? host_ready : core_ready});
				get(!inb, t, mq.pop_front());
			end
		join
		repeat (2) get(!inb, t, mq.pop_front());
		get(!inb, t, `MXU_EMPTY_WORD);
		settle(1'b0, 1'b1);
	endtask : q_test

	initial begin
		#100000;
		error_cnt++;
		$display("[FAIL] watchdog expired");
		end_of_test();
	end

	initial begin
		nrst = 1'b0;
		core_req = '0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		settle(1'b0, 1'b1);
		// ---
		// doorbells
		// ---
		d = $random(seed) | 32'h1;
		host_u.wr(`MXU_TGT_IN_DB, d);
		settle(1'b1, 1'b1);
		get(1'b0, `MXU_TGT_IN_DB, d);
		put(1'b0, `MXU_TGT_IN_DB, d & ~32'h1);
		settle(1'b1, 1'b1);
		get(1'b0, `MXU_TGT_IN_DB, 32'h1);
		put(1'b0, `MXU_TGT_IN_DB, 32'h1);
		settle(1'b0, 1'b1);
		d = $random(seed) | 32'h3;
		put(1'b0, `MXU_TGT_OUT_DB, d);
		settle(1'b0, 1'b0);
		host_u.wr(`MXU_TGT_OUT_DB, d & ~32'h1);
		settle(1'b0, 1'b0);
		put(1'b0, `MXU_TGT_OUT_MSG0, d);
		host_u.wr(`MXU_TGT_OUT_DB, 32'h1);
		settle(1'b0, 1'b0);
		get(1'b1, `MXU_TGT_OUT_MSG0, d);
		get(1'b1, 4'hf, `MXU_UNMAPPED_WORD);
		settle(1'b0, 1'b1);
		// ---
		// message registers and queues
		// ---
		for (int i = 0; i < 2; i++) begin
			d = $random(seed);
			host_u.wr(`MXU_TGT_IN_MSG0 + 4'(i), d);
			settle(1'b1, 1'b1);
			get(1'b0, `MXU_TGT_IN_MSG0 + 4'(i), d);
			settle(1'b0, 1'b1);
			put(1'b0, `MXU_TGT_OUT_MSG0 + 4'(i), ~d);
			settle(1'b0, 1'b0);
			get(1'b1, `MXU_TGT_OUT_MSG0 + 4'(i), ~d);
			settle(1'b0, 1'b1);
			q_test(1'b1, `MXU_TGT_IN_Q0 + 4'(i));
			q_test(1'b0, `MXU_TGT_OUT_Q0 + 4'(i));
		end
		end_of_test();
	end
endmodule : testbench
